// *** hdl/ast_pkg.sv ***
package ast_pkg;
  typedef enum logic [1:0] {
    AST_PD_8N = 2'b00,
    AST_PD_8E = 2'b01,
    AST_PD_8O = 2'b10,
    AST_PD_9N = 2'b11
  } ast_pd_t;
  typedef enum logic [2:0] {
    AST_S_IDLE = 3'b000,
    AST_S_START = 3'b001,
    AST_S_DATA = 3'b010,
    AST_S_PAR = 3'b011,
    AST_S_STOP = 3'b100
  } ast_state_t;
endpackage

// *** hdl/ast_regs.svh ***
`ifndef AST_REGS_SVH
`define AST_REGS_SVH
// ---------------------------------------------
// Register byte addresses
// ---------------------------------------------
`define AST_OFF_MODE 12'h000
`define AST_OFF_STA 12'h004
`define AST_OFF_TXREG 12'h008
`define AST_OFF_RXREG 12'h00c
`define AST_OFF_BRG 12'h010
// ---------------------------------------------
// line_config_word fields
// ---------------------------------------------
`define AST_MODE_ON 15
`define AST_MODE_ALT 10
`define AST_MODE_LPBK 6
`define AST_MODE_PD_HI 2
`define AST_MODE_PD_LO 1
`define AST_MODE_STOP 0
`define AST_MODE_RST 16'h0000
// ---------------------------------------------
// Status word fields
// ---------------------------------------------
`define AST_STA_TXISEL 15
`define AST_STA_BRK 11
`define AST_STA_TXON 10
`define AST_STA_TXBF 9
`define AST_STA_TX_SHIFT_EMPTY 8
`define AST_STA_RXISEL_HI 7
`define AST_STA_RXISEL_LO 6
`define AST_STA_ADDRESS_DETECT_ON 5
`define AST_STA_RX_LINE_IDLE 4
`define AST_STA_PARITY_ERROR_FLAG 3
`define AST_STA_FRAMING_ERROR_FLAG 2
`define AST_STA_RX_OVERRUN_FLAG 1
`define AST_STA_RXDA 0
`define AST_BRG_RST 16'h0000
`define AST_FIFO_DEPTH 4
`endif

// *** hdl/ast_uart.sv ***
`include "ast_regs.svh"
module ast_uart (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  input wire logic alt_serial_in_pin,
  input wire logic port_tx_dir,
  input wire logic port_tx_latch,
  input wire logic port_rx_dir,
  input wire logic port_rx_latch,
  input wire logic port_alt_tx_dir,
  input wire logic port_alt_tx_latch,
  input wire logic port_alt_rx_dir,
  input wire logic port_alt_rx_latch,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic alt_serial_out_pin,
  output logic alt_serial_out_oe,
  output logic serial_in_oe,
  output logic serial_in_out,
  output logic alt_serial_in_oe,
  output logic alt_serial_in_out,
  output logic tx_irq,
  output logic rx_irq
);
  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  logic [15:0] line_config_word;
  logic [15:0] baud_divisor;
  logic tx_irq_select, tx_break, tx_on, address_detect_on;
  logic [1:0] rx_irq_select;
  logic rx_overrun_flag;
  logic [1:0] rx_sync;
  logic [15:0] baud_cnt;
  logic [3:0] tick_cnt;
  logic [8:0] tx_mem [0:3];
  logic [1:0] tx_wp, tx_rp;
  logic [2:0] tx_cnt;
  logic [10:0] rx_mem [0:3];
  logic [1:0] rx_wp, rx_rp;
  logic [2:0] rx_cnt;
  ast_pkg::ast_state_t tx_st, rx_st;
  logic [8:0] tx_sh, rx_sh;
  logic [3:0] tx_bit, rx_bit;
  logic tx_par, rx_par, tx_line, rx_framing_error_flag, rx_parity_error_flag_q;
  logic [3:0] rx_tick;

  // ---------------------------------------------
  // Decode
  // ---------------------------------------------
  wire uart_on = line_config_word[`AST_MODE_ON];
  wire alt = line_config_word[`AST_MODE_ALT];
  wire lpbk = line_config_word[`AST_MODE_LPBK];
  wire two_stop = line_config_word[`AST_MODE_STOP];
  wire [1:0] pd = line_config_word[`AST_MODE_PD_HI:`AST_MODE_PD_LO];
  wire nine = (pd == ast_pkg::AST_PD_9N);
  wire par_on = (pd == ast_pkg::AST_PD_8E) || (pd == ast_pkg::AST_PD_8O);
  wire odd = (pd == ast_pkg::AST_PD_8O);
  wire [3:0] nbits = nine ? 4'h9 : 4'h8;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire mapped = (paddr == `AST_OFF_MODE) || (paddr == `AST_OFF_STA) || (paddr == `AST_OFF_TXREG) ||
                (paddr == `AST_OFF_RXREG) || (paddr == `AST_OFF_BRG);
  wire wr_mode = wr && paddr == `AST_OFF_MODE;
  wire wr_sta = wr && paddr == `AST_OFF_STA;
  wire wr_tx = wr && paddr == `AST_OFF_TXREG;
  wire rd_rx = rd && paddr == `AST_OFF_RXREG;
  wire wr_brg = wr && paddr == `AST_OFF_BRG;
  wire off = !uart_on;
  wire tx_full = (tx_cnt == 3'(`AST_FIFO_DEPTH));
  wire rx_full = (rx_cnt == 3'(`AST_FIFO_DEPTH));
  wire tx_push = wr_tx && !tx_full && uart_on;
  // 16x oversample tick
  wire tick = uart_on && (baud_cnt == baud_divisor);
  wire bit_tick = tick && (tick_cnt == 4'hf);
  wire tx_load = bit_tick && tx_st == ast_pkg::AST_S_IDLE && tx_on && tx_cnt != 3'h0 && !tx_break;
  wire rx_src = lpbk ? tx_line : rx_sync[1];
  wire rx_mid = tick && (rx_tick == 4'h7);
  wire rx_done = rx_mid && rx_st == ast_pkg::AST_S_STOP && (!two_stop || rx_bit == 4'h1);
  wire rx_parity_error_flag_now = par_on && rx_parity_error_flag_q;
  wire [10:0] rx_word = {rx_framing_error_flag || !rx_src, rx_parity_error_flag_now, rx_sh};
  wire rx_push = rx_done && !rx_full && !rx_overrun_flag;
  wire rx_ovr = rx_done && rx_full;
  wire rx_pop = rd_rx && rx_cnt != 3'h0;
  wire [10:0] rx_top = rx_mem[rx_rp];
  wire tx_shift_empty = tx_st == ast_pkg::AST_S_IDLE;
  wire rx_line_idle = rx_st == ast_pkg::AST_S_IDLE;
  wire [15:0] sta_word = {tx_irq_select, 3'h0, tx_break, tx_on, tx_full, tx_shift_empty, rx_irq_select,
                          address_detect_on, rx_line_idle, rx_top[9] & (rx_cnt != 3'h0),
                          rx_top[10] & (rx_cnt != 3'h0), rx_overrun_flag, rx_cnt != 3'h0};
  wire [15:0] rd_mux = (paddr == `AST_OFF_MODE) ? line_config_word :
                       (paddr == `AST_OFF_STA) ? sta_word :
                       (paddr == `AST_OFF_RXREG) ? {7'h00, rx_top[8:0]} :
                       (paddr == `AST_OFF_BRG) ? baud_divisor : 16'h0000;
  wire [2:0] rx_cnt_after = rx_cnt + 3'h1;
  wire rx_irq_ev = rx_push && (!address_detect_on || rx_sh[8]) &&
                   (rx_irq_select[1] == 1'b0 || (rx_irq_select == 2'b10 && rx_cnt_after == 3'h3) ||
                    (rx_irq_select == 2'b11 && rx_cnt_after == 3'h4));
  wire tx_irq_ev = tx_load && (!tx_irq_select || tx_cnt == 3'h1);
  wire tx_drv = tx_break ? 1'b0 : tx_line;
  wire pin_val = lpbk ? 1'b1 : tx_drv;

  // ---------------------------------------------
  // APB slave
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= {16'h0000, rd_mux};
    end
  end

  // ---------------------------------------------
  // Control registers
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_config_word <= `AST_MODE_RST;
      baud_divisor <= `AST_BRG_RST;
      tx_irq_select <= 1'b0;
      rx_irq_select <= 2'b00;
      address_detect_on <= 1'b0;
      tx_on <= 1'b0;
      tx_break <= 1'b0;
      rx_overrun_flag <= 1'b0;
    end else begin
      if (wr_mode && pready) line_config_word <= pwdata[15:0];
      if (wr_brg && pready) baud_divisor <= pwdata[15:0];
      if (wr_sta && pready) begin
        tx_irq_select <= pwdata[`AST_STA_TXISEL];
        rx_irq_select <= pwdata[`AST_STA_RXISEL_HI:`AST_STA_RXISEL_LO];
        address_detect_on <= pwdata[`AST_STA_ADDRESS_DETECT_ON];
      end
      if (off) begin
        tx_on <= 1'b0;
        tx_break <= 1'b0;
        rx_overrun_flag <= 1'b0;
      end else begin
        if (wr_sta && pready) begin
          tx_on <= pwdata[`AST_STA_TXON];
          tx_break <= pwdata[`AST_STA_BRK];
        end
        // Set wins over software clear
        if (rx_ovr) rx_overrun_flag <= 1'b1;
        else if (wr_sta && pready && !pwdata[`AST_STA_RX_OVERRUN_FLAG]) rx_overrun_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Baud generator and pin sync
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= 16'h0000;
      tick_cnt <= 4'h0;
      rx_sync <= 2'b11;
    end else begin
      rx_sync <= {rx_sync[0], alt ? alt_serial_in_pin : serial_in_pin};
      if (off) begin
        baud_cnt <= 16'h0000;
        tick_cnt <= 4'h0;
      end else if (tick) begin
        baud_cnt <= 16'h0000;
        tick_cnt <= tick_cnt + 4'h1;
      end else begin
        baud_cnt <= baud_cnt + 16'h0001;
      end
    end
  end

  // ---------------------------------------------
  // Buffers
  // ---------------------------------------------
  always_ff @(posedge pclk) begin
    if (tx_push && pready) tx_mem[tx_wp] <= pwdata[8:0];
    if (rx_push) rx_mem[rx_wp] <= rx_word;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp <= 2'h0;
      tx_rp <= 2'h0;
      tx_cnt <= 3'h0;
      rx_wp <= 2'h0;
      rx_rp <= 2'h0;
      rx_cnt <= 3'h0;
    end else if (off) begin
      tx_wp <= 2'h0;
      tx_rp <= 2'h0;
      tx_cnt <= 3'h0;
      rx_wp <= 2'h0;
      rx_rp <= 2'h0;
      rx_cnt <= 3'h0;
    end else begin
      if (tx_push && pready) tx_wp <= tx_wp + 2'h1;
      if (tx_load) tx_rp <= tx_rp + 2'h1;
      tx_cnt <= tx_cnt + {2'h0, tx_push && pready} - {2'h0, tx_load};
      if (rx_push) rx_wp <= rx_wp + 2'h1;
      if (rx_pop && pready) rx_rp <= rx_rp + 2'h1;
      rx_cnt <= rx_cnt + {2'h0, rx_push} - {2'h0, rx_pop && pready};
    end
  end

  // ---------------------------------------------
  // Transmitter
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= ast_pkg::AST_S_IDLE;
      tx_sh <= 9'h000;
      tx_bit <= 4'h0;
      tx_par <= 1'b0;
      tx_line <= 1'b1;
    end else if (off) begin
      tx_st <= ast_pkg::AST_S_IDLE;
      tx_line <= 1'b1;
    end else if (bit_tick) begin
      unique case (tx_st)
        ast_pkg::AST_S_IDLE: begin
          tx_line <= 1'b1;
          if (tx_load) begin
            tx_sh <= tx_mem[tx_rp];
            tx_par <= odd;
            tx_bit <= 4'h0;
            tx_line <= 1'b0;
            tx_st <= ast_pkg::AST_S_DATA;
          end
        end
        ast_pkg::AST_S_DATA: begin
          tx_line <= tx_sh[0];
          tx_par <= tx_par ^ tx_sh[0];
          tx_sh <= {1'b0, tx_sh[8:1]};
          tx_bit <= tx_bit + 4'h1;
          if (tx_bit == nbits - 4'h1) tx_st <= par_on ? ast_pkg::AST_S_PAR : ast_pkg::AST_S_STOP;
        end
        ast_pkg::AST_S_PAR: begin
          tx_line <= tx_par;
          tx_bit <= 4'h0;
          tx_st <= ast_pkg::AST_S_STOP;
        end
        ast_pkg::AST_S_STOP: begin
          tx_line <= 1'b1;
          tx_bit <= 4'h0;
          if (!two_stop || tx_bit == 4'h1) tx_st <= ast_pkg::AST_S_IDLE;
          else tx_bit <= 4'h1;
        end
        default: tx_st <= ast_pkg::AST_S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // Receiver
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= ast_pkg::AST_S_IDLE;
      rx_sh <= 9'h000;
      rx_bit <= 4'h0;
      rx_par <= 1'b0;
      rx_tick <= 4'h0;
      rx_framing_error_flag <= 1'b0;
      rx_parity_error_flag_q <= 1'b0;
    end else if (off) begin
      rx_st <= ast_pkg::AST_S_IDLE;
      rx_tick <= 4'h0;
    end else if (tick) begin
      rx_tick <= rx_tick + 4'h1;
      unique case (rx_st)
        ast_pkg::AST_S_IDLE: begin
          rx_tick <= 4'h0;
          if (!rx_src && !rx_overrun_flag) rx_st <= ast_pkg::AST_S_START;
        end
        ast_pkg::AST_S_START:
          if (rx_mid) begin
            rx_tick <= 4'h8;
            rx_bit <= 4'h0;
            rx_par <= odd;
            rx_framing_error_flag <= 1'b0;
            rx_sh <= 9'h000;
            rx_st <= rx_src ? ast_pkg::AST_S_IDLE : ast_pkg::AST_S_DATA;
          end
        ast_pkg::AST_S_DATA:
          if (rx_mid) begin
            rx_sh <= nine ? {rx_src, rx_sh[8:1]} : {1'b0, rx_src, rx_sh[7:1]};
            rx_par <= rx_par ^ rx_src;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == nbits - 4'h1) begin
              rx_bit <= 4'h0;
              rx_st <= par_on ? ast_pkg::AST_S_PAR : ast_pkg::AST_S_STOP;
            end
          end
        ast_pkg::AST_S_PAR:
          if (rx_mid) begin
            rx_parity_error_flag_q <= rx_par ^ rx_src;
            rx_st <= ast_pkg::AST_S_STOP;
          end
        ast_pkg::AST_S_STOP:
          if (rx_mid) begin
            rx_framing_error_flag <= rx_framing_error_flag || !rx_src;
            rx_bit <= rx_bit + 4'h1;
            if (rx_done) begin
              rx_st <= ast_pkg::AST_S_IDLE;
              rx_parity_error_flag_q <= 1'b0;
            end
          end
        default: rx_st <= ast_pkg::AST_S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // Pins and interrupts
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b0;
      serial_out_oe <= 1'b0;
      alt_serial_out_pin <= 1'b0;
      alt_serial_out_oe <= 1'b0;
      serial_in_oe <= 1'b0;
      serial_in_out <= 1'b0;
      alt_serial_in_oe <= 1'b0;
      alt_serial_in_out <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      // Port direction bit high means input
      serial_out_pin <= (uart_on && !alt) ? pin_val : port_tx_latch;
      serial_out_oe <= (uart_on && !alt) ? 1'b1 : !port_tx_dir;
      alt_serial_out_pin <= (uart_on && alt) ? pin_val : port_alt_tx_latch;
      alt_serial_out_oe <= (uart_on && alt) ? 1'b1 : !port_alt_tx_dir;
      serial_in_out <= port_rx_latch;
      serial_in_oe <= (uart_on && !alt) ? 1'b0 : !port_rx_dir;
      alt_serial_in_out <= port_alt_rx_latch;
      alt_serial_in_oe <= (uart_on && alt) ? 1'b0 : !port_alt_rx_dir;
      tx_irq <= tx_irq_ev && !off;
      rx_irq <= rx_irq_ev && !off;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  AST_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    off |=> tx_shift_empty && rx_line_idle && tx_cnt == 3'h0 && !tx_on)
    else $error("port off but state not cleared");
  AST_FULL_IGN: assert property (@(posedge pclk) disable iff (!presetn)
    tx_full && !tx_load |=> tx_cnt == 3'h4)
    else $error("full tx buffer changed");
  AST_IDLE_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    tx_st == ast_pkg::AST_S_IDLE && $past(tx_st) == ast_pkg::AST_S_IDLE && !tx_break |-> tx_line)
    else $error("idle tx line low");
  AST_LPBK_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    uart_on && lpbk && !alt |=> serial_out_pin && serial_out_oe)
    else $error("loopback pin not high");
  AST_RX_PIN: assert property (@(posedge pclk) disable iff (!presetn) uart_on && !alt |=> !serial_in_oe)
    else $error("receive pin not released to input");
  AST_BAUD_RST: assert property (@(posedge pclk) disable iff (!presetn) off |=> baud_cnt == 16'h0000)
    else $error("baud counter not reset while off");
endmodule

// *** verif/ast_remote.sv ***
module ast_remote (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int bitc = 16;
  int nbits = 8;
  int par = 0;
  int stops = 1;
  int bad = 0;
  logic [8:0] rxq[$];
  initial line_out = 1'b1;
  // ---------------------------------------------
  // Send one character, optionally corrupted
  // ---------------------------------------------
  task automatic send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < nbits; i++) begin
      q.push_back(d[i]);
    end
    if (par != 0) begin
      q.push_back((^d[7:0]) ^ (par == 2) ^ bad_par);
    end
    for (int s = 0; s < stops; s++) begin
      q.push_back(!(bad_stop && s == stops - 1));
    end
    foreach (q[i]) begin
      line_out <= q[i];
      repeat (bitc) @(posedge clk);
    end
    line_out <= 1'b1;
    @(posedge clk);
  endtask
  // ---------------------------------------------
  // Receiver, samples at bit centres
  // ---------------------------------------------
  always begin
    logic [8:0] d;
    @(negedge line_in);
    d = '0;
    repeat (bitc / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bitc) @(posedge clk);
      d[i] = line_in;
    end
    if (par != 0) begin
      repeat (bitc) @(posedge clk);
      if (line_in !== ((^d[7:0]) ^ (par == 2))) bad++;
    end
    for (int s = 0; s < stops; s++) begin
      repeat (bitc) @(posedge clk);
      if (line_in !== 1'b1) bad++;
    end
    rxq.push_back(d);
  end
endmodule

// *** verif/ast_uart_tb.sv ***
`include "ast_regs.svh"
module ast_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_out_pin, serial_out_oe, alt_serial_out_pin, alt_serial_out_oe;
  logic serial_in_oe, serial_in_out, alt_serial_in_oe, alt_serial_in_out, tx_irq, rx_irq;
  logic [7:0] pcfg = 8'h55;
  logic alt_sel = 1'b0;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int txn = 0;
  int rxn = 0;
  int lowcnt = 0;
  int k;
  wire logic to_rem;
  wire logic from_rem;
  // ---------------------------------------------
  // Wiring, released lines pulled high
  // ---------------------------------------------
  assign to_rem = alt_sel ? (alt_serial_out_oe ? alt_serial_out_pin : 1'b1) : (serial_out_oe ? serial_out_pin : 1'b1);
  ast_uart u_ast_uart (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_in_pin(alt_sel ? 1'b1 : from_rem), .alt_serial_in_pin(alt_sel ? from_rem : 1'b1),
    .port_tx_dir(pcfg[0]), .port_tx_latch(pcfg[1]), .port_rx_dir(pcfg[2]), .port_rx_latch(pcfg[3]),
    .port_alt_tx_dir(pcfg[4]), .port_alt_tx_latch(pcfg[5]), .port_alt_rx_dir(pcfg[6]),
    .port_alt_rx_latch(pcfg[7]), .serial_out_pin, .serial_out_oe, .alt_serial_out_pin, .alt_serial_out_oe,
    .serial_in_oe, .serial_in_out, .alt_serial_in_oe, .alt_serial_in_out, .tx_irq, .rx_irq);
  ast_remote remote (.clk(pclk), .line_in(to_rem), .line_out(from_rem));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (tx_irq === 1'b1) txn <= txn + 1;
    if (rx_irq === 1'b1) rxn <= rxn + 1;
    if (serial_out_pin !== 1'b1) lowcnt <= lowcnt + 1;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] got);
    checked++;
    if (got !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, rd & m);
  endtask
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while (rd[b] !== v && n < 600) begin
      apb(1'b0, a, 32'h0);
      n++;
    end
  endtask
  task automatic rx_get(input logic [31:0] e);
    poll(`AST_OFF_STA, 0, 1'b1);
    chk("rx data", `AST_OFF_RXREG, 32'h1ff, e);
  endtask
  task automatic get_tx(input logic [31:0] e);
    int n;
    n = 0;
    while (remote.rxq.size() == 0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    cmp("tx frame", e, (remote.rxq.size() > 0) ? 32'(remote.rxq.pop_front()) : 32'hdead_beef);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset();
    chk("mode", `AST_OFF_MODE, 32'hffff, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    cmp("unmapped err", 32'h1, {31'h0, err});
    pcfg <= 8'h56;
    repeat (3) @(posedge pclk);
    cmp("port tx", 32'h6, {29'h0, serial_out_oe, serial_out_pin, serial_in_oe});
    pcfg <= 8'h59;
    repeat (3) @(posedge pclk);
    cmp("port rx", 32'h3, {29'h0, serial_out_oe, serial_in_oe, serial_in_out});
    pcfg <= 8'h55;
  endtask
  task automatic t_formats();
    for (int m = 0; m < 8; m++) begin
      logic [8:0] d;
      logic [8:0] r;
      logic nine;
      nine = (m[2:1] == 2'b11);
      d = 9'h1a5 ^ 9'(m);
      r = 9'h15a ^ 9'(m);
      remote.nbits = nine ? 9 : 8;
      remote.par = nine ? 0 : m[2:1];
      remote.stops = m[0] + 1;
      apb(1'b1, `AST_OFF_MODE, 32'h8000 | m);
      apb(1'b1, `AST_OFF_STA, 32'h0400);
      cmp("on pins", 32'h6, {29'h0, serial_out_oe, serial_out_pin, serial_in_oe});
      apb(1'b1, `AST_OFF_TXREG, 32'(d));
      fork
        remote.send(r, 1'b0, 1'b0);
        get_tx(32'(nine ? d : {1'b0, d[7:0]}));
      join
      rx_get(32'(nine ? r : {1'b0, r[7:0]}));
      cmp("remote errors", 32'h0, remote.bad);
    end
  endtask
  task automatic t_errors();
    remote.nbits = 8;
    remote.par = 1;
    remote.stops = 2;
    apb(1'b1, `AST_OFF_MODE, 32'h8003);
    remote.send(9'h033, 1'b1, 1'b0);
    poll(`AST_OFF_STA, 0, 1'b1);
    cmp("parity flag", 32'h8, rd & 32'hc);
    apb(1'b0, `AST_OFF_RXREG, 32'h0);
    remote.send(9'h044, 1'b0, 1'b1);
    poll(`AST_OFF_STA, 0, 1'b1);
    cmp("framing flag", 32'h4, rd & 32'hc);
    apb(1'b0, `AST_OFF_RXREG, 32'h0);
  endtask
  task automatic t_tx_full();
    remote.par = 0;
    remote.stops = 1;
    apb(1'b1, `AST_OFF_MODE, 32'h8000);
    k = txn;
    apb(1'b1, `AST_OFF_TXREG, 32'h10);
    poll(`AST_OFF_STA, 8, 1'b0);
    for (int i = 1; i < 6; i++) begin
      apb(1'b1, `AST_OFF_TXREG, 32'h10 + i);
    end
    chk("tx full", `AST_OFF_STA, 32'h200, 32'h200);
    for (int i = 0; i < 5; i++) begin
      get_tx(32'h10 + i);
    end
    cmp("tx irq count", 32'd5, txn - k);
  endtask
  task automatic t_overrun();
    k = rxn;
    for (int i = 0; i < 5; i++) begin
      remote.send(9'h020 + 9'(i), 1'b0, 1'b0);
    end
    poll(`AST_OFF_STA, 1, 1'b1);
    cmp("rx irq count", 32'd4, rxn - k);
    for (int i = 0; i < 4; i++) begin
      chk("rx fifo", `AST_OFF_RXREG, 32'h1ff, 32'h20 + i);
    end
  endtask
  task automatic t_disable();
    remote.bitc = 32;
    remote.stops = 2;
    apb(1'b1, `AST_OFF_BRG, 32'h1);
    apb(1'b1, `AST_OFF_MODE, 32'h8001);
    apb(1'b1, `AST_OFF_STA, 32'h84e0);
    apb(1'b1, `AST_OFF_TXREG, 32'h77);
    apb(1'b1, `AST_OFF_TXREG, 32'h78);
    poll(`AST_OFF_STA, 8, 1'b0);
    apb(1'b1, `AST_OFF_MODE, 32'h0001);
    chk("mode kept", `AST_OFF_MODE, 32'hffff, 32'h0001);
    cmp("off oe", 32'h0, {31'h0, serial_out_oe});
    chk("off status", `AST_OFF_STA, 32'hffff, 32'h81f0);
    chk("divisor kept", `AST_OFF_BRG, 32'hffff, 32'h1);
    repeat (400) @(posedge pclk);
    remote.rxq.delete();
    remote.bad = 0;
    apb(1'b1, `AST_OFF_MODE, 32'h8001);
    chk("empty buffers", `AST_OFF_STA, 32'h203, 32'h0);
    apb(1'b1, `AST_OFF_STA, 32'h0400);
    apb(1'b1, `AST_OFF_TXREG, 32'h3c);
    get_tx(32'h3c);
    apb(1'b1, `AST_OFF_BRG, 32'h0);
    remote.bitc = 16;
    remote.stops = 1;
  endtask
  task automatic t_loop_alt_addr();
    apb(1'b1, `AST_OFF_MODE, 32'h8040);
    k = lowcnt;
    apb(1'b1, `AST_OFF_TXREG, 32'h96);
    rx_get(32'h96);
    cmp("pin held high", k, lowcnt);
    apb(1'b1, `AST_OFF_MODE, 32'h8400);
    alt_sel <= 1'b1;
    apb(1'b1, `AST_OFF_TXREG, 32'h5e);
    get_tx(32'h5e);
    fork
      remote.send(9'h033, 1'b0, 1'b0);
      rx_get(32'h33);
    join
    remote.nbits = 9;
    apb(1'b1, `AST_OFF_MODE, 32'h8406);
    apb(1'b1, `AST_OFF_STA, 32'h0420);
    k = rxn;
    remote.send(9'h012, 1'b0, 1'b0);
    remote.send(9'h1a5, 1'b0, 1'b0);
    poll(`AST_OFF_STA, 0, 1'b1);
    cmp("address irq count", 32'd1, rxn - k);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_formats();
    t_errors();
    t_tx_full();
    t_overrun();
    t_disable();
    t_loop_alt_addr();
    cmp("remote errors", 32'h0, remote.bad);
    report_and_stop();
  end
endmodule
